/* File: swd_core_model.sv */
// Processor core model that issues one-cycle watchdog commands
module swd_core_model
    import swd_pkg::*;
(
    // Clock
    input  wire logic ref_clk,
    // Commands to the watchdog
    output swd_cmd_t  cmd
);
    timeunit 1ns;
    timeprecision 100ps;

    // Quiet until the bench asks for a command
    initial cmd = '0;

    // Kind 2 services, 1 disables, 0 enables; strobe lasts one edge only
    task automatic issue(input int kind);
        @(posedge ref_clk);
        #1;
        cmd = swd_cmd_t'(3'h1 << kind);
        @(posedge ref_clk);
        #1;
        cmd = '0;
    endtask : issue
endmodule : swd_core_model

/* File: swd_pkg.sv */
// Package for the system watchdog: constants, defaults and signal bundles
package swd_pkg;

    // Counter and prescaler widths
    localparam int CNT_W   = 16;
    localparam int PRE_W   = 14;

    // Prescaler terminal counts, one tick per N system clocks
    localparam logic [PRE_W-1:0] PRE_LAST_SLOW = 14'h3FFF;  // Divide by 16,384
    localparam logic [PRE_W-1:0] PRE_LAST_FAST = 14'h00FF;  // Divide by 256
    localparam int               PRE_DIV_FAST  = 256;

    // Counter all-ones value, the point of wrap
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

    // Default interval at power-up, given at the reference system rate
    localparam int DEF_INTERVAL_US = 6500;
    localparam int DEF_FSYS_MHZ    = 10;
    localparam int DEF_CYCLES      = DEF_INTERVAL_US * DEF_FSYS_MHZ;
    // Ticks rounded up so the interval is never shorter than stated
    localparam int DEF_TICKS       = (DEF_CYCLES + PRE_DIV_FAST - 1) / PRE_DIV_FAST;
    localparam logic [CNT_W-1:0] RELOAD_DEF = CNT_W'(65536 - DEF_TICKS);
    localparam logic             PRESEL_DEF = 1'b0;         // 0 = divide by 256

    // Gap between prewarning and reset request, in system clocks
    localparam logic [7:0] WARN_CYCLES = 8'h10;

    // Single-cycle commands from the processor core
    typedef struct packed {
        logic service;   // Reload counter, clear prescaler
        logic wd_off;    // watchdog_off_cmd
        logic wd_on;     // watchdog_on_cmd
    } swd_cmd_t;

    // Software configuration, taken on cfg_wr
    typedef struct packed {
        logic [CNT_W-1:0] reload_value_field;  // Counter start value
        logic             presel_slow;         // 1 = divide by 16,384
    } swd_cfg_t;

    // Block state seen by software
    typedef struct packed {
        logic             enabled;   // Counting allowed
        logic             overflow;  // Overflow has occurred
        logic [CNT_W-1:0] count;     // Current counter value
    } swd_stat_t;

    // Sequencer states
    typedef enum logic [1:0] {
        SWD_RUN,
        SWD_WARN,
        SWD_RESET
    } swd_state_t;

endpackage : swd_pkg

/* File: swd_watchdog.sv */
// System watchdog: prescaler, 16-bit counter, prewarning and reset request
module swd_watchdog
    import swd_pkg::*;
(
    // Clock and reset
    input  wire logic      ref_clk,
    input  wire logic      rst,
    // Commands from the processor core
    input  wire swd_cmd_t  cmd,
    // Configuration write
    input  wire logic      cfg_wr,
    input  wire swd_cfg_t  cfg,
    // Events to the system
    output logic           prewarn_irq,
    output logic           reset_req,
    // Status
    output swd_stat_t      stat
);

    // Stored configuration
    swd_cfg_t         cfg_r;        // Reload and prescaler choice
    logic             enabled_r;    // Counting allowed
    logic [PRE_W-1:0] pre_r;        // Prescaler count
    logic [CNT_W-1:0] cnt_r;        // Watchdog counter
    swd_state_t       state_r;      // Sequencer state
    logic [7:0]       warn_r;       // Cycles since prewarning
    logic             prewarn_r;    // Prewarning pulse
    logic             reset_req_r;  // Reset request level
    logic             overflow_r;   // Sticky overflow flag

    // Derived controls
    logic             running;      // Counting in this cycle
    logic             tick;         // Prescaler terminal reached
    logic             wrap;         // Counter wraps on this tick
    logic [PRE_W-1:0] pre_last;     // Active terminal count

    // Counting only while enabled and before an overflow has been seen
    assign running  = enabled_r && (state_r == SWD_RUN);
    assign pre_last = cfg_r.presel_slow ? PRE_LAST_SLOW : PRE_LAST_FAST;
    assign tick     = running && (pre_r == pre_last) && !cmd.service;
    assign wrap     = tick && (cnt_r == CNT_MAX);

    // Configuration register, defaults chosen for the power-up interval
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_r.reload_value_field <= RELOAD_DEF;
            cfg_r.presel_slow        <= PRESEL_DEF;
        end else if (cfg_wr) begin
            // New reload takes effect at the next service
            cfg_r <= cfg;
        end
    end

    // Enable flag; on wins when both strobes coincide, the safer choice
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            enabled_r <= 1'b1;
        end else if (cmd.wd_on) begin
            enabled_r <= 1'b1;
        end else if (cmd.wd_off) begin
            enabled_r <= 1'b0;
        end
    end

    // Prescaler, cleared by service and held while stopped
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pre_r <= '0;
        end else if (cmd.service) begin
            pre_r <= '0;
        end else if (running) begin
            // Wrap at the selected terminal count
            if (pre_r == pre_last) begin
                pre_r <= '0;
            end else begin
                pre_r <= pre_r + PRE_W'(1);
            end
        end
    end

    // Counter, reloaded by service, advanced on ticks
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= RELOAD_DEF;
        end else if (cmd.service && state_r == SWD_RUN) begin
            cnt_r <= cfg_r.reload_value_field;
        end else if (tick) begin
            // Wraps to zero at overflow, then frozen
            cnt_r <= cnt_r + CNT_W'(1);
        end
    end

    // Overflow sequencer: prewarning first, reset request later
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= SWD_RUN;
            warn_r  <= '0;
        end else begin
            unique case (state_r)
                SWD_RUN: begin
                    // Missed service ends up here
                    if (wrap) begin
                        state_r <= SWD_WARN;
                        warn_r  <= '0;
                    end
                end
                SWD_WARN: begin
                    // Gives software time to save state; cannot be cancelled
                    if (warn_r == WARN_CYCLES - 8'h01) begin
                        state_r <= SWD_RESET;
                    end else begin
                        warn_r <= warn_r + 8'h01;
                    end
                end
                SWD_RESET: begin
                    // Held until the system reset clears the block
                    state_r <= SWD_RESET;
                end
            endcase
        end
    end

    // Event outputs and sticky overflow flag
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prewarn_r   <= 1'b0;
            reset_req_r <= 1'b0;
            overflow_r  <= 1'b0;
        end else begin
            prewarn_r <= wrap;
            if (wrap) begin
                overflow_r <= 1'b1;
            end
            if (state_r == SWD_WARN && warn_r == WARN_CYCLES - 8'h01) begin
                reset_req_r <= 1'b1;
            end
        end
    end

    // Outputs straight from flip-flops
    assign prewarn_irq   = prewarn_r;
    assign reset_req     = reset_req_r;
    assign stat.enabled  = enabled_r;
    assign stat.overflow = overflow_r;
    assign stat.count    = cnt_r;

    // Assertions
    AST_RESET_ENABLED: assert property (@(posedge ref_clk)
        $fell(rst) |-> enabled_r && cnt_r == RELOAD_DEF && !reset_req)
        else $error("watchdog not enabled after reset");

    AST_OFF_STOPS: assert property (@(posedge ref_clk) disable iff (rst)
        cmd.wd_off && !cmd.wd_on |=> !stat.enabled)
        else $error("off command did not stop watchdog");

    AST_ON_RESUMES: assert property (@(posedge ref_clk) disable iff (rst)
        cmd.wd_on |=> stat.enabled)
        else $error("on command did not enable watchdog");

    AST_STOPPED_HOLDS: assert property (@(posedge ref_clk) disable iff (rst)
        !enabled_r && !cmd.service && !cfg_wr |=> $stable(cnt_r) && $stable(pre_r))
        else $error("counter moved while stopped");

    AST_PREWARN_THEN_RESET: assert property (@(posedge ref_clk) disable iff (rst)
        prewarn_irq |-> !reset_req ##16 reset_req)
        else $error("reset request not after prewarning");

    AST_NO_EARLY_RESET: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(reset_req) |-> $past(state_r) == SWD_WARN && overflow_r)
        else $error("reset request without overflow");

    AST_SERVICE_RELOADS: assert property (@(posedge ref_clk) disable iff (rst)
        cmd.service && state_r == SWD_RUN |=> cnt_r == $past(cfg_r.reload_value_field) && pre_r == '0)
        else $error("service did not reload and clear");

    AST_FAST_DIVIDE: assert property (@(posedge ref_clk) disable iff (rst)
        running && !cfg_r.presel_slow && pre_r == PRE_LAST_FAST && !cmd.service |=> pre_r == '0)
        else $error("prescaler did not wrap at 256");

    AST_TICK_STEP: assert property (@(posedge ref_clk) disable iff (rst)
        tick && cnt_r != CNT_MAX |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("counter did not step by one");

    AST_PREWARN_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
        prewarn_irq |=> !prewarn_irq)
        else $error("prewarning longer than one cycle");

    // Cover properties
    COV_OVERFLOW: cover property (@(posedge ref_clk) disable iff (rst) $rose(reset_req));
    COV_SERVICE: cover property (@(posedge ref_clk) disable iff (rst) cmd.service && cnt_r != RELOAD_DEF);
    COV_OFF_ON: cover property (@(posedge ref_clk) disable iff (rst) cmd.wd_off ##[1:20] cmd.wd_on);

endmodule : swd_watchdog

/* File: swd_watchdog_tb.sv */
// Self-checking bench for the system watchdog
module swd_watchdog_tb
    import swd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic      ref_clk;      // 40 MHz system clock
    logic      rst;          // Async reset, high
    swd_cmd_t  cmd;          // From core model
    logic      cfg_wr;       // Config strobe
    swd_cfg_t  cfg;          // Config value
    logic      prewarn_irq;  // Prewarning pulse
    logic      reset_req;    // Reset request level
    swd_stat_t stat;         // Status bundle
    int        n_fail;       // Mismatches
    int        checks_done;  // Comparisons made
    int        seed;         // Fixed seed for repeatability
    int        n;            // Cycle count of a wait
    int        k;            // Random command kind
    logic [15:0] rl;         // Random reload

    swd_watchdog i_dut (.ref_clk(ref_clk), .rst(rst), .cmd(cmd), .cfg_wr(cfg_wr), .cfg(cfg),
                        .prewarn_irq(prewarn_irq), .reset_req(reset_req), .stat(stat));
    swd_core_model i_core (.ref_clk(ref_clk), .cmd(cmd));

    // Free-running clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Compare and report
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s exp=%h seen=%h", what, exp, seen);
        end
    endtask : chk

    // Moves land 1 ns after the k-th edge, or 1 ns on from now when k is 0, away from sampling
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : step

    // Config write, strobe held across one edge
    task automatic write_cfg(input logic [15:0] r, input logic s);
        cfg_wr = 1'b1;
        cfg = '{r, s};
        step(1);
        cfg_wr = 1'b0;
    endtask : write_cfg

    // Bounded wait for prewarning or reset request
    task automatic wait_ev(input bit on_rst, input int lim, output int cnt);
        cnt = 0;
        do begin
            step(1);
            cnt++;
        end while (((on_rst ? reset_req : prewarn_irq) !== 1'b1) && cnt < lim);
        if (cnt >= lim) begin
            n_fail++;
            $display("[ERR] event wait exp=within %0d seen=none", lim);
            end_sim();
        end
    endtask : wait_ev

    // Verdict
    task automatic end_sim();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    // Main sequence
    initial begin
        rst = 1'b1;
        cfg_wr = 1'b0;
        cfg = '0;
        n_fail = 0;
        checks_done = 0;
        seed = 23;
        step(10);
        rst = 1'b0;
        chk("enabled", stat.enabled, 1);
        chk("count", stat.count, 16'hFF02);
        // One tick per 256 clocks after reset
        step(128);
        chk("count", stat.count, 16'hFF02);
        step(256);
        chk("count", stat.count, 16'hFF03);
        // Service mid-period: prescaler must restart too
        write_cfg(16'hFFF0, 1'b0);
        i_core.issue(2);
        chk("count", stat.count, 16'hFFF0);
        step(200);
        chk("count", stat.count, 16'hFFF0);
        step(100);
        chk("count", stat.count, 16'hFFF1);
        // Off freezes, on resumes
        i_core.issue(1);
        chk("enabled", stat.enabled, 0);
        step(600);
        chk("count", stat.count, 16'hFFF1);
        i_core.issue(0);
        chk("enabled", stat.enabled, 1);
        // Random reloads, serviced well before any tick
        // Random on/off before each service; service acts while stopped too
        repeat (8) begin
            k = $random(seed) & 1;
            i_core.issue(k);
            chk("enabled", stat.enabled, 32'(k == 0));
            rl = {8'hFF, 8'($random(seed))};
            write_cfg(rl, 1'($random(seed)));
            step(32'($random(seed)) & 63);
            i_core.issue(2);
            chk("count", stat.count, {16'h0, rl});
            chk("prewarn", prewarn_irq, 0);
        end
        i_core.issue(0);
        chk("enabled", stat.enabled, 1);
        // Overflow after two fast ticks
        write_cfg(16'hFFFE, 1'b0);
        i_core.issue(2);
        wait_ev(1'b0, 600, n);
        chk("ovf_delay", (n >= 511 && n <= 513), 1);
        chk("count", stat.count, 0);
        chk("overflow", stat.overflow, 1);
        step(1);
        chk("prewarn", prewarn_irq, 0);
        chk("reset_req", reset_req, 0);
        wait_ev(1'b1, 40, n);
        chk("req_delay", n, 15);
        // Service after overflow is ignored, request stays
        i_core.issue(2);
        chk("count", stat.count, 0);
        chk("reset_req", reset_req, 1);
        // Reset in mid-run brings back the enabled state
        rst = 1'b1;
        step(10);
        rst = 1'b0;
        chk("reset_req", reset_req, 0);
        chk("enabled", stat.enabled, 1);
        chk("overflow", stat.overflow, 0);
        // Slow prescaler, one tick to overflow
        write_cfg(16'hFFFF, 1'b1);
        i_core.issue(2);
        wait_ev(1'b0, 17000, n);
        chk("slow_delay", (n >= 16383 && n <= 16385), 1);
        end_sim();
    end
endmodule : swd_watchdog_tb
